// ==== dpot_pkg.sv ====
package dpot_pkg;

    // Register indices on the serial link
    localparam logic [7:0] REG_POSITION   = 8'h00;
    localparam logic [7:0] REG_CONFIG_SEL = 8'h01;
    localparam logic [7:0] REG_ACCESS     = 8'h02;

    // Reset and shipped values
    localparam logic [6:0] POS_MIDSCALE   = 7'h40;
    localparam logic [6:0] POS_SHIPPED    = 7'h40;

    // Field positions
    localparam int ACC_WIPER_ONLY_BIT     = 7;
    localparam int ACC_ACTIVE_BIT         = 6;
    localparam int ACC_BUSY_BIT           = 5;
    localparam int CFG_DIVIDER_BIT        = 7;
    localparam int CFG_PREC_OFF_BIT       = 6;

    // Identification byte: 01010, strap bit, 0, read/write
    localparam logic [4:0] ID_PREFIX      = 5'h0A;
    localparam logic       ID_FIXED_ZERO  = 1'b0;

    // Time of the self-timed non-volatile write
    localparam int CLK_HZ                 = 50_000_000;
    localparam int NV_WRITE_MS            = 20;
    localparam int NV_WRITE_CYCLES        = CLK_HZ / 1000 * NV_WRITE_MS;
    // Supply ramp before non-volatile reads are reliable
    localparam int RECALL_DELAY_CYCLES    = 16;

    // Serial engine states
    typedef enum logic [2:0] {
        DPOT_IDLE   = 3'b000,
        DPOT_ID     = 3'b001,
        DPOT_ID_ACK = 3'b011,
        DPOT_RX     = 3'b010,
        DPOT_RX_ACK = 3'b110,
        DPOT_TX     = 3'b111,
        DPOT_TX_ACK = 3'b101
    } dpot_state_t;

    // Analog-facing controls
    typedef struct packed {
        logic [6:0] position;
        logic       active;
        logic       divider_mode;
        logic       precision_off;
    } dpot_ctrl_t;

endpackage

// ==== dpot_top.sv ====
// Summary of operation
// - 7-bit position drives wiper; 00h at low, 7Fh at high terminal
// - Wiper position forced to 40h while power comes up
// - After supply settles, stored initial position copied to wiper
// - Non-volatile initial-position store holds 40h as shipped
// - Address 0 reaches store or wiper, chosen by wiper-only select
// - Configuration select register mapped at address 1
// - Access-control register mapped at address 2
// - Access bit 7: 0 targets store, 1 targets wiper only
// - Every write to the store also loads the wiper
// - Wiper-only select resets to 0
// - Access bit 6: 0 shuts down, 1 active, default 1
// - Access bit 5 read-only, 1 while non-volatile write runs
// - While busy, writes to wiper or access register ignored
// - Configuration bit 7: 0 rheostat, 1 divider, default 0
// - Configuration bit 6 set disables precision matching, default 0
// - Configuration bits 5..0 ignore writes; host ignores their value
// - One address bit compared against strap pin; respond only on match
// - Two devices per bus at 50h and 54h by strap level
// - Data sampled on clock rise, changed after clock fall
// - Data line open-drain: pull low or release only
// - Id byte 01010, strap, 0, read/write; ack only on match
// - Write: id, address, data, stop; non-volatile write starts at stop after a store or configuration write
// - Read: id write, address, restart, id read, bytes until nack
module dpot_top #(
    parameter int NV_CYCLES = dpot_pkg::NV_WRITE_CYCLES
) (
    input  wire logic              CLK_IN,
    input  wire logic              SYS_RST_IN,
    input  wire logic              SCL_IN,
    input  wire logic              SDA_IN,
    input  wire logic              ADDRESS_STRAP_PIN_IN,
    output logic                   SDA_OUT,
    output logic                   SDA_OE_OUT,
    output dpot_pkg::dpot_ctrl_t   CTRL_OUT,
    output logic                   NV_WRITE_BUSY_OUT
);

    // Two-flop synchronisers; first stage read only by second
    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic [1:0] strap_sync_r;
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            scl_sync_r   <= 3'h7;
            sda_sync_r   <= 3'h7;
            strap_sync_r <= 2'h0;
        end else begin
            scl_sync_r   <= {scl_sync_r[1:0], SCL_IN};
            sda_sync_r   <= {sda_sync_r[1:0], SDA_IN};
            strap_sync_r <= {strap_sync_r[0], ADDRESS_STRAP_PIN_IN};
        end
    end

    logic scl_s;
    logic sda_s;
    logic scl_prev;
    logic sda_prev;
    assign scl_s    = scl_sync_r[1];
    assign sda_s    = sda_sync_r[1];
    assign scl_prev = scl_sync_r[2];
    assign sda_prev = sda_sync_r[2];

    // Edges of the synced lines; start and stop need clock high twice
    logic scl_rise;
    logic scl_fall;
    logic sda_fall;
    logic sda_rise;
    logic start_det;
    logic stop_det;
    assign scl_rise  = scl_s & ~scl_prev;
    assign scl_fall  = ~scl_s & scl_prev;
    assign sda_fall  = sda_prev & ~sda_s;
    assign sda_rise  = ~sda_prev & sda_s;
    assign start_det = scl_s & scl_prev & sda_fall;
    assign stop_det  = scl_s & scl_prev & sda_rise;

    // Registers of the block
    logic [6:0] store_r;         // Non-volatile image
    logic [6:0] wiper_r;
    logic       wiper_only_r;
    logic       active_r;
    logic       divider_r;
    logic       prec_off_r;
    logic       busy_r;
    localparam int BUSY_W = $clog2(NV_CYCLES + 1);
    logic [BUSY_W-1:0] busy_cnt_r;
    logic [4:0] recall_cnt_r;
    logic       recalled_r;

    // Serial engine
    dpot_pkg::dpot_state_t state_r;
    logic [7:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] addr_r;
    logic [1:0] byte_idx_r;      // 0 id, 1 address, 2 data
    logic       reading_r;
    logic       nv_pending_r;    // Store or configuration written this frame
    logic       sda_low_r;

    logic       wr_strobe;
    logic [7:0] wr_data;
    assign wr_data = shift_r;

    // Read mux; reserved configuration bits read zero
    logic [7:0] rd_data;
    always_comb begin
        rd_data = 8'h00;
        unique case (addr_r)
            dpot_pkg::REG_POSITION:
                rd_data = {1'b0, wiper_only_r ? wiper_r : store_r};
            dpot_pkg::REG_CONFIG_SEL:
                rd_data = {divider_r, prec_off_r, 6'h00};
            dpot_pkg::REG_ACCESS:
                rd_data = {wiper_only_r, active_r, busy_r, 5'h00};
            default: rd_data = 8'h00;
        endcase
    end

    // Id byte match: fixed prefix, strap bit, fixed zero
    logic id_match;
    assign id_match = (shift_r[7:3] == dpot_pkg::ID_PREFIX)
        && (shift_r[2] == strap_sync_r[1])
        && (shift_r[1] == dpot_pkg::ID_FIXED_ZERO);

    // Protocol state machine
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            state_r    <= dpot_pkg::DPOT_IDLE;
            shift_r    <= 8'h00;
            bit_cnt_r  <= 4'h0;
            addr_r     <= 8'h00;
            byte_idx_r <= 2'h0;
            reading_r  <= 1'b0;
            sda_low_r  <= 1'b0;
        end else if (start_det && recalled_r) begin
            // Start ignored until power-up recall finished
            state_r   <= dpot_pkg::DPOT_ID;
            bit_cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
        end else if (stop_det) begin
            state_r    <= dpot_pkg::DPOT_IDLE;
            byte_idx_r <= 2'h0;
            sda_low_r  <= 1'b0;
        end else begin
            unique case (state_r)
                dpot_pkg::DPOT_IDLE: sda_low_r <= 1'b0;
                dpot_pkg::DPOT_ID, dpot_pkg::DPOT_RX: begin
                    if (scl_rise) begin
                        shift_r   <= {shift_r[6:0], sda_s};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                    if (scl_fall && bit_cnt_r == 4'h8) begin
                        bit_cnt_r <= 4'h0;
                        if (state_r == dpot_pkg::DPOT_ID) begin
                            if (id_match) begin
                                sda_low_r <= 1'b1;
                                reading_r <= shift_r[0];
                                state_r   <= dpot_pkg::DPOT_ID_ACK;
                            end else begin
                                state_r <= dpot_pkg::DPOT_IDLE;
                            end
                        end else begin
                            sda_low_r <= 1'b1;
                            state_r   <= dpot_pkg::DPOT_RX_ACK;
                            if (byte_idx_r == 2'h1) begin
                                addr_r <= shift_r;
                            end else if (addr_r < dpot_pkg::REG_ACCESS) begin
                                addr_r <= addr_r + 8'h01;
                            end
                            byte_idx_r <= 2'h2;
                        end
                    end
                end
                dpot_pkg::DPOT_ID_ACK: begin
                    if (scl_fall) begin
                        if (reading_r) begin
                            shift_r   <= rd_data;
                            sda_low_r <= ~rd_data[7];
                            bit_cnt_r <= 4'h1;
                            state_r   <= dpot_pkg::DPOT_TX;
                        end else begin
                            sda_low_r  <= 1'b0;
                            byte_idx_r <= 2'h1;
                            state_r    <= dpot_pkg::DPOT_RX;
                        end
                    end
                end
                dpot_pkg::DPOT_RX_ACK: begin
                    if (scl_fall) begin
                        sda_low_r <= 1'b0;
                        state_r   <= dpot_pkg::DPOT_RX;
                    end
                end
                dpot_pkg::DPOT_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == 4'h8) begin
                            sda_low_r <= 1'b0;                 // Master acks
                            state_r   <= dpot_pkg::DPOT_TX_ACK;
                            // Next byte of a burst, held at the last one
                            if (addr_r < dpot_pkg::REG_ACCESS) begin
                                addr_r <= addr_r + 8'h01;
                            end
                        end else begin
                            shift_r   <= {shift_r[6:0], 1'b0};
                            sda_low_r <= ~shift_r[6];
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end
                    end
                end
                dpot_pkg::DPOT_TX_ACK: begin
                    if (scl_rise) begin
                        reading_r <= ~sda_s;
                    end
                    if (scl_fall) begin
                        if (reading_r) begin
                            shift_r   <= rd_data;
                            sda_low_r <= ~rd_data[7];
                            bit_cnt_r <= 4'h1;
                            state_r   <= dpot_pkg::DPOT_TX;
                        end else begin
                            state_r <= dpot_pkg::DPOT_IDLE;
                        end
                    end
                end
                default: state_r <= dpot_pkg::DPOT_IDLE;
            endcase
        end
    end

    // Data byte complete: write strobe at the ack's drive point
    assign wr_strobe = ~start_det & ~stop_det
        && state_r == dpot_pkg::DPOT_RX && scl_fall
        && bit_cnt_r == 4'h8 && byte_idx_r == 2'h2;

    // Register writes; all are dropped while the store is busy
    logic wr_pos_ok;
    logic wr_store_ok;
    logic wr_cfg_ok;
    logic wr_acc_ok;
    assign wr_pos_ok   = wr_strobe && !busy_r
        && addr_r == dpot_pkg::REG_POSITION;
    assign wr_store_ok = wr_pos_ok && !wiper_only_r;
    assign wr_cfg_ok   = wr_strobe && !busy_r
        && addr_r == dpot_pkg::REG_CONFIG_SEL;
    assign wr_acc_ok   = wr_strobe && !busy_r
        && addr_r == dpot_pkg::REG_ACCESS;

    // Pull low or release only; never drive high
    assign SDA_OUT    = 1'b0;
    assign SDA_OE_OUT = sda_low_r;

    // Recall timer; starts are refused until the supply has settled
    logic recall_now;
    assign recall_now = !recalled_r
        && recall_cnt_r == 5'(dpot_pkg::RECALL_DELAY_CYCLES);
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            recall_cnt_r <= 5'h00;
            recalled_r   <= 1'b0;
        end else if (!recalled_r) begin
            recall_cnt_r <= recall_cnt_r + 5'h01;
            recalled_r   <= recall_now;
        end
    end

    // Wiper: midscale at power-up, then recall, then user writes
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            wiper_r <= dpot_pkg::POS_MIDSCALE;
        end else if (recall_now) begin
            wiper_r <= store_r;
        end else if (recalled_r && wr_pos_ok) begin
            wiper_r <= wr_data[6:0];
        end
    end

    // Non-volatile store; kept across system reset like real memory
    logic store_init_r = 1'b0;
    always_ff @(posedge CLK_IN) begin
        store_init_r <= 1'b1;
        if (!store_init_r) begin
            store_r <= dpot_pkg::POS_SHIPPED;
        end else if (wr_store_ok) begin
            store_r <= wr_data[6:0];
        end
    end

    // Configuration bits; reserved bits 5..0 have no storage
    always_ff @(posedge CLK_IN) begin
        if (!store_init_r) begin
            divider_r  <= 1'b0;
            prec_off_r <= 1'b0;
        end else if (wr_cfg_ok) begin
            divider_r  <= wr_data[dpot_pkg::CFG_DIVIDER_BIT];
            prec_off_r <= wr_data[dpot_pkg::CFG_PREC_OFF_BIT];
        end
    end

    // Access-control register; low bits not stored
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            wiper_only_r <= 1'b0;
            active_r     <= 1'b1;
        end else if (wr_acc_ok) begin
            wiper_only_r <= wr_data[dpot_pkg::ACC_WIPER_ONLY_BIT];
            active_r     <= wr_data[dpot_pkg::ACC_ACTIVE_BIT];
        end
    end

    // Pending flag: a store or configuration byte awaits the stop
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            nv_pending_r <= 1'b0;
        end else if (stop_det) begin
            nv_pending_r <= 1'b0;
        end else if (wr_store_ok || wr_cfg_ok) begin
            nv_pending_r <= 1'b1;
        end
    end

    // Busy timer: a stop launches the self-timed write; set wins
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) begin
            busy_r     <= 1'b0;
            busy_cnt_r <= '0;
        end else if (stop_det && nv_pending_r) begin
            busy_r     <= 1'b1;
            busy_cnt_r <= '0;
        end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
            if (busy_cnt_r == BUSY_W'(NV_CYCLES - 1)) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Analog controls from flops
    assign CTRL_OUT.position      = wiper_r;
    assign CTRL_OUT.active        = active_r;
    assign CTRL_OUT.divider_mode  = divider_r;
    assign CTRL_OUT.precision_off = prec_off_r;
    assign NV_WRITE_BUSY_OUT      = busy_r;

endmodule

// ==== dpot_monitor.sv ====
module dpot_monitor #(
    parameter int NV_CYCLES = 1000
) (
    input wire logic                 CLK_IN,
    input wire logic                 SYS_RST_IN,
    input wire logic                 SCL_IN,
    input wire logic                 SDA_IN,
    input wire logic                 ADDRESS_STRAP_PIN_IN,
    input wire logic                 SDA_OUT,
    input wire logic                 SDA_OE_OUT,
    input wire dpot_pkg::dpot_ctrl_t CTRL_OUT,
    input wire logic                 NV_WRITE_BUSY_OUT
);
    timeunit 1ns;
    timeprecision 100ps;
    int         busy_cnt_r;
    logic [5:0] rel_cnt_r;

    // Length of the current busy stretch
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN || !NV_WRITE_BUSY_OUT) busy_cnt_r <= 0;
        else busy_cnt_r <= busy_cnt_r + 1;
    end

    // Settle time; recall after reset may move the wiper on its own
    always_ff @(posedge CLK_IN) begin
        if (SYS_RST_IN) rel_cnt_r <= '0;
        else if (!rel_cnt_r[5]) rel_cnt_r <= rel_cnt_r + 6'h01;
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    a_sda_drain_only: assert property (SDA_OUT == 1'b0)
        else $error("data line driven high");
    a_reset_values: assert property ($fell(SYS_RST_IN) |->
        CTRL_OUT.position == 7'h40 && CTRL_OUT.active
        && !NV_WRITE_BUSY_OUT && !SDA_OE_OUT)
        else $error("wrong values after reset");
    a_oe_hold_high: assert property (SCL_IN && $past(SCL_IN)
        && $past(SCL_IN, 2) && $past(SCL_IN, 3) |-> $stable(SDA_OE_OUT))
        else $error("data drive changed while clock high");
    a_oe_rise_low: assert property ($rose(SDA_OE_OUT) |->
        !$past(SCL_IN, 2))
        else $error("data drive began outside clock low");
    a_busy_length: assert property ($fell(NV_WRITE_BUSY_OUT) |->
        busy_cnt_r >= NV_CYCLES - 1 && busy_cnt_r <= NV_CYCLES + 1)
        else $error("busy length wrong");
    a_busy_after_stop: assert property ($rose(NV_WRITE_BUSY_OUT) |->
        SCL_IN && SDA_IN)
        else $error("busy began while bus not idle");
    a_busy_freeze: assert property (NV_WRITE_BUSY_OUT
        && $past(NV_WRITE_BUSY_OUT) |-> $stable(CTRL_OUT))
        else $error("controls changed while busy");
    a_wiper_cause: assert property (rel_cnt_r[5]
        && $changed(CTRL_OUT.position) |-> SDA_OE_OUT || $past(SDA_OE_OUT))
        else $error("wiper moved outside a write");
    a_mode_cause: assert property (rel_cnt_r[5] && $changed({
        CTRL_OUT.active, CTRL_OUT.divider_mode, CTRL_OUT.precision_off})
        |-> SDA_OE_OUT || $past(SDA_OE_OUT))
        else $error("mode changed outside a write");
endmodule

// ==== dpot_master.sv ====
module dpot_master (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_pull_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle bus: clock parked high, data released
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    // Changes land just after a system clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Start or repeated start; data falls while clock high
    task automatic start();
        tick(1);
        sda_pull_out = 1'b0;
        tick(3);
        scl_out = 1'b1;
        tick(4);
        sda_pull_out = 1'b1;
        tick(4);
        scl_out = 1'b0;
    endtask

    // Stop, then idle long enough for the device to see it
    task automatic stop();
        tick(1);
        sda_pull_out = 1'b1;
        tick(3);
        scl_out = 1'b1;
        tick(4);
        sda_pull_out = 1'b0;
        tick(8);
    endtask

    // One bit: data set after the fall, sampled mid high
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_pull_out = ~b;
        tick(3);
        scl_out = 1'b1;
        tick(2);
        r = sda_in;
        tick(2);
        scl_out = 1'b0;
    endtask

    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            q[i] = r;
        end
        bit_io(mack, r);
        ack = ~r;
    endtask

    task automatic wr(input logic strap, input logic [7:0] adr,
                      input logic [7:0] dat, output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        start();
        xfer({dpot_pkg::ID_PREFIX, strap, dpot_pkg::ID_FIXED_ZERO, 1'b0},
             1'b1, q, a0);
        xfer(adr, 1'b1, q, a1);
        xfer(dat, 1'b1, q, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask

    // One byte read, ended by no-ack and stop
    task automatic rd(input logic strap, input logic [7:0] adr,
                      output logic [7:0] dat, output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        start();
        xfer({dpot_pkg::ID_PREFIX, strap, dpot_pkg::ID_FIXED_ZERO, 1'b0},
             1'b1, q, a0);
        xfer(adr, 1'b1, q, a1);
        start();
        xfer({dpot_pkg::ID_PREFIX, strap, dpot_pkg::ID_FIXED_ZERO, 1'b1},
             1'b1, q, a2);
        xfer(8'hFF, 1'b1, dat, a3);
        stop();
        ok = a0 & a1 & a2;
    endtask
endmodule

// ==== dpot_test.sv ====
module dpot_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NV_CYCLES = 1500;
    localparam int LIMIT     = 40000;
    logic                 clk;
    logic                 rst;
    logic                 strap;
    logic                 scl;
    logic                 sda_pull;
    logic                 sda_oe;
    logic                 sda_out;
    logic                 busy;
    logic                 sda_w;
    logic                 ok;
    dpot_pkg::dpot_ctrl_t ctrl;
    int                   error_cnt = 0;
    int                   check_count = 0;
    int                   cycles = 0;

    // Open-drain wire with pull-up
    assign sda_w = ~(sda_oe | sda_pull);

    dpot_top #(.NV_CYCLES(NV_CYCLES)) i_dpot_top (
        .CLK_IN(clk), .SYS_RST_IN(rst), .SCL_IN(scl), .SDA_IN(sda_w),
        .ADDRESS_STRAP_PIN_IN(strap), .SDA_OUT(sda_out),
        .SDA_OE_OUT(sda_oe), .CTRL_OUT(ctrl), .NV_WRITE_BUSY_OUT(busy));
    dpot_master i_dpot_master (.clk_in(clk), .sda_in(sda_w),
        .scl_out(scl), .sda_pull_out(sda_pull));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        i_dpot_master.wr(strap, a, d, k);
        check({7'h00, k}, 8'h01);
    endtask

    // Read with a mask so ignored bits do not count
    task automatic rd(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        logic       k;
        logic [7:0] q;
        i_dpot_master.rd(strap, a, q, k);
        check({7'h00, k}, 8'h01);
        check(q & m, e);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        #1;
        check({7'h00, busy}, 8'h00);
    endtask

    function automatic logic [7:0] mode();
        return {5'h00, ctrl.active, ctrl.divider_mode, ctrl.precision_off};
    endfunction

    task complete_run();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        strap = 1'b0;
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (70) @(posedge clk);
        #1;
        check({1'b0, ctrl.position}, 8'h40);
        check(mode(), 8'h04);
        rd(8'h00, 8'hFF, 8'h40);
        rd(8'h02, 8'hFF, 8'h40);
        rd(8'h01, 8'hC0, 8'h00);
        $display("reset values done");
        wr(8'h00, 8'h7F);
        check({7'h00, busy}, 8'h01);
        check({1'b0, ctrl.position}, 8'h7F);
        rd(8'h02, 8'hFF, 8'h60);
        wr(8'h02, 8'h80);
        wr(8'h00, 8'h11);
        check({1'b0, ctrl.position}, 8'h7F);
        rd(8'h02, 8'hFF, 8'h60);
        wait_idle();
        rd(8'h02, 8'hFF, 8'h40);
        $display("store write done");
        wr(8'h01, 8'hFF);
        wait_idle();
        check(mode(), 8'h07);
        rd(8'h01, 8'hC0, 8'hC0);
        wr(8'h01, 8'h40);
        wait_idle();
        check(mode(), 8'h05);
        $display("mode register done");
        wr(8'h02, 8'hBF);
        check({7'h00, busy}, 8'h00);
        rd(8'h02, 8'hFF, 8'h80);
        check(mode(), 8'h01);
        wr(8'h00, 8'h00);
        check({7'h00, busy}, 8'h00);
        check({1'b0, ctrl.position}, 8'h00);
        rd(8'h00, 8'hFF, 8'h00);
        wr(8'h02, 8'h40);
        rd(8'h00, 8'hFF, 8'h7F);
        $display("wiper only done");
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            #1 strap = s[0];
            rd(8'h02, 8'hFF, 8'h40);
            i_dpot_master.wr(~strap, 8'h00, 8'h11, ok);
            check({7'h00, ok}, 8'h00);
            check({1'b0, ctrl.position}, 8'h00);
        end
        strap = 1'b0;
        $display("strap match done");
        wr(8'h02, 8'hC0);
        wr(8'h00, 8'h22);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check({1'b0, ctrl.position}, 8'h40);
        rst = 1'b0;
        repeat (70) @(posedge clk);
        #1;
        check({1'b0, ctrl.position}, 8'h7F);
        check(mode(), 8'h05);
        rd(8'h02, 8'hFF, 8'h40);
        $display("second reset done");
        complete_run();
    end
endmodule

bind dpot_top dpot_monitor #(.NV_CYCLES(NV_CYCLES)) i_dpot_monitor (
    .CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .ADDRESS_STRAP_PIN_IN(ADDRESS_STRAP_PIN_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .CTRL_OUT(CTRL_OUT),
    .NV_WRITE_BUSY_OUT(NV_WRITE_BUSY_OUT));
